// ===== hw/timer_evt_defs.vh
`ifndef TIMER_EVT_DEFS_VH
`define TIMER_EVT_DEFS_VH

// Register byte offsets on the bus.
`define OFS_ENABLE 8'h0c
`define OFS_FLAGS 8'h10
`define OFS_EVGEN 8'h14
`define OFS_CHCTL 8'h18
`define OFS_CV0 8'h34
`define OFS_CV1 8'h38

// Bit positions in the enable, flag and event generation registers.
`define BIT_UPD 0
`define BIT_CH0 1
`define BIT_TRG 6
`define BIT_UPD_DMA 8
`define BIT_CH0_DMA 9
`define BIT_OVC0 9

// Implemented bits and reset value.
`define ENABLE_MASK 16'h5f5f
`define FLAG_MASK 16'h1e5f
`define GEN_MASK 16'h005f
`define RST16 16'h0000

// Field positions inside one channel byte of the channel control register.
`define CF_MS 0
`define CF_FEN 2
`define CF_SEN 3
`define CF_CTL 4
`define CF_CEN 7
`define CH_SPAN 8

// Channel mode and protection encodings.
`define MODE_OUT 2'b00
`define WRITE_PROTECT_LEVEL_FULL 2'b11

// Reference control encodings.
`define REF_FROZEN 3'b000
`define REF_SET 3'b001
`define REF_CLR 3'b010
`define REF_TOG 3'b011
`define REF_LOW 3'b100
`define REF_HIGH 3'b101
`define REF_PWM0 3'b110
`define REF_PWM1 3'b111

// Slave mode encodings that matter for trigger events.
`define SLV_OFF 3'b000
`define SLV_PAUSE 3'b101

`endif

// ===== hw/cmp_ref_unit.v
`timescale 1ns/1ps
`default_nettype none
`include "timer_evt_defs.vh"

module cmp_ref_unit #(
  parameter CNT_W = 16
) (
  // Clock and reset.
  input wire clk_i,
  input wire rst_i,
  // Channel setup.
  input wire [2:0] mode_i,
  input wire clear_en_i,
  input wire ext_clear_i,
  input wire out_mode_i,
  // Counter and compare value.
  input wire [CNT_W-1:0] count_i,
  input wire [CNT_W-1:0] cmp_i,
  input wire count_down_i,
  // Reference and compare event.
  output wire ref_o,
  output wire match_evt_o
);

  reg ref_reg;
  reg match_prev_reg;
  reg lvl_prev_reg;
  reg [2:0] mode_prev_reg;
  reg match_evt_reg;

  wire match = (count_i == cmp_i);
  wire pwm_act = count_down_i ? !(count_i > cmp_i) : (count_i < cmp_i);
  wire lvl = (mode_i == `REF_PWM1) ? !pwm_act : pwm_act;

  assign ref_o = ref_reg;
  assign match_evt_o = match_evt_reg;

  // Reference update; toggling uses the match edge so a stalled counter toggles once.
  always @(posedge clk_i) begin
    if (rst_i) begin
      ref_reg <= 1'b0;
      match_prev_reg <= 1'b0;
      lvl_prev_reg <= 1'b0;
      mode_prev_reg <= `REF_FROZEN;
      match_evt_reg <= 1'b0;
    end else begin
      match_prev_reg <= match;
      lvl_prev_reg <= lvl;
      mode_prev_reg <= mode_i;
      match_evt_reg <= out_mode_i & match & !match_prev_reg;
      if (clear_en_i && ext_clear_i) begin
        ref_reg <= 1'b0;
      end else begin
        case (mode_i)
          `REF_FROZEN: ref_reg <= ref_reg;
          `REF_SET: if (match) ref_reg <= 1'b1;
          `REF_CLR: if (match) ref_reg <= 1'b0;
          `REF_TOG: if (match && !match_prev_reg) ref_reg <= !ref_reg;
          `REF_LOW: ref_reg <= 1'b0;
          `REF_HIGH: ref_reg <= 1'b1;
          default: begin
            if (mode_prev_reg == `REF_FROZEN || lvl != lvl_prev_reg) ref_reg <= lvl;
          end
        endcase
      end
    end
  end

endmodule // cmp_ref_unit
`default_nettype wire

// ===== hw/timer_event_flags_and_compare_ctl.v
// Function
// - Channel 0 and update DMA requests only when bits 9 and 8 enable them.
// - Interrupt asserted only for flags whose enable bit is set.
// - Capture while channel flag already set raises its over-capture flag.
// - Trigger event sets trigger flag, held until software clears it.
// - Trigger on rising edge only when slave mode is not off; in pause mode on both edges.
// - Channel flag set by capture in input mode, compare in output mode.
// - Update event sets update flag until software clears it.
// - Trigger generation bit sets trigger flag and self-clears.
// - Channel generation bit sets flag, captures in input mode on channels 0 and 1, self-clears.
// - Update generation reinitialises counter and prescaler, then self-clears.
// - Mode field writable only while channel disabled; three input selections.
// - Clear enable forces reference low while external trigger high.
// - Modes 000 to 011: hold, set, clear, toggle on match.
// - Modes 100 and 101 force reference low or high.
// - PWM mode 0 level follows counter versus compare value.
// - PWM mode 1 is the inverse of PWM mode 0.
// - PWM reference changes only on entry from hold or result change.
// - Control and shadow bits locked under full protection in output mode.
// - Shadow enable defers compare value to the next update event.
// - Reference active high; outputs use their own polarity bits.
`timescale 1ns/1ps
`default_nettype none
`include "timer_evt_defs.vh"

module timer_event_flags_and_compare_ctl #(
  parameter CNT_W = 16
) (
  // Clock and reset.
  input wire clk_i,
  input wire rst_i,
  // Wishbone slave.
  input wire [7:0] adr_i,
  input wire [31:0] dat_i,
  input wire [3:0] sel_i,
  input wire we_i,
  input wire cyc_i,
  input wire stb_i,
  output reg [31:0] dat_o,
  output reg ack_o,
  // Counter core and slave controller.
  input wire [CNT_W-1:0] timer_count_value_i,
  input wire count_down_i,
  input wire hw_update_i,
  input wire trigger_input_i,
  input wire [2:0] slave_mode_i,
  // Channel status from the rest of the timer.
  input wire [3:0] ch_enable_i,
  input wire [3:0] ch_hw_evt_i,
  input wire [1:0] ch_upper_input_i,
  input wire [1:0] write_protect_level_i,
  input wire filtered_ext_trigger_i,
  // Output polarity settings.
  input wire ch_zero_out_polarity_i,
  input wire ch_zero_compl_polarity_i,
  input wire ch_one_out_polarity_i,
  // Requests and channel outputs.
  output reg irq_o,
  output reg update_dma_req_o,
  output reg ch_zero_dma_req_o,
  output reg counter_reinit_o,
  output reg [1:0] ch_ref_o,
  output reg ch_zero_out_o,
  output reg ch_zero_out_compl_o,
  output reg ch_one_out_o
);

  ////////////////////////////////////////////////////////////////////////////
  // Declarations.

  reg [15:0] enable_reg;
  reg [15:0] flags_reg;
  reg [15:0] flags_next;
  reg [15:0] gen_reg;
  reg [15:0] chctl_reg;
  reg [15:0] chctl_next;
  reg [CNT_W-1:0] cv_pre_reg [0:1];
  reg [CNT_W-1:0] cv_act_reg [0:1];
  reg trg_prev_reg;
  reg [31:0] rd_data;
  reg [15:0] clr_mask;
  reg [3:0] ch_in;
  reg [3:0] ch_evt;
  reg [3:0] cap_evt;
  integer i;
  integer j;
  integer k;
  integer m;

  wire [1:0] ref_w;
  wire [1:0] match_w;
  wire [15:0] wdat = dat_i[15:0];
  wire [15:0] lane = {{8{sel_i[1]}}, {8{sel_i[0]}}};

  ////////////////////////////////////////////////////////////////////////////
  // Bus timing.

  // Writes land on the edge where the master samples ack, so a write
  // is applied once per ack; a request held on is acked and applied again every second cycle.
  wire req = cyc_i & stb_i;
  wire wr = req & we_i & ack_o;
  wire wr_enable = wr & (adr_i == `OFS_ENABLE);
  wire wr_flags = wr & (adr_i == `OFS_FLAGS);
  wire wr_gen = wr & (adr_i == `OFS_EVGEN);
  wire wr_chctl = wr & (adr_i == `OFS_CHCTL);
  wire wr_cv0 = wr & (adr_i == `OFS_CV0);
  wire wr_cv1 = wr & (adr_i == `OFS_CV1);

  // Ack one cycle after the request; read data is latched with it.
  always @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
      dat_o <= 32'h0000_0000;
    end else begin
      ack_o <= req & !ack_o;
      if (req && !ack_o) begin
        dat_o <= rd_data;
      end
    end
  end

  // Read multiplexer; unmapped addresses and the generation register read zero.
  always @* begin
    rd_data = 32'h0000_0000;
    case (adr_i)
      `OFS_ENABLE: rd_data[15:0] = enable_reg;
      `OFS_FLAGS: rd_data[15:0] = flags_reg;
      `OFS_CHCTL: rd_data[15:0] = chctl_reg;
      `OFS_CV0: rd_data[CNT_W-1:0] = cv_pre_reg[0];
      `OFS_CV1: rd_data[CNT_W-1:0] = cv_pre_reg[1];
      default: rd_data = 32'h0000_0000;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Events.

  wire trg_edge = (slave_mode_i == `SLV_PAUSE) ? (trigger_input_i ^ trg_prev_reg) :
                  ((slave_mode_i != `SLV_OFF) & trigger_input_i & !trg_prev_reg);
  wire trg_evt = trg_edge | gen_reg[`BIT_TRG];
  wire upd_evt = hw_update_i | gen_reg[`BIT_UPD];

  // Channel events; channels 0 and 1 take compare matches from their own units.
  always @* begin
    ch_in = {ch_upper_input_i, chctl_reg[`CH_SPAN+`CF_MS +: 2] != `MODE_OUT,
             chctl_reg[`CF_MS +: 2] != `MODE_OUT};
    ch_evt = ch_hw_evt_i | gen_reg[`BIT_CH0 +: 4];
    for (i = 0; i < 2; i = i + 1) begin
      if (!ch_in[i]) begin
        ch_evt[i] = match_w[i] | gen_reg[`BIT_CH0+i];
      end
    end
    cap_evt = ch_evt & ch_in;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Flags.

  // A set in the same cycle as a software clear wins, so no event is lost.
  always @* begin
    clr_mask = wr_flags ? (~wdat & lane) : `RST16;
    flags_next = flags_reg & ~clr_mask;
    if (upd_evt) flags_next[`BIT_UPD] = 1'b1;
    if (trg_evt) flags_next[`BIT_TRG] = 1'b1;
    for (j = 0; j < 4; j = j + 1) begin
      if (ch_evt[j]) flags_next[`BIT_CH0+j] = 1'b1;
      if (cap_evt[j] && flags_reg[`BIT_CH0+j]) flags_next[`BIT_OVC0+j] = 1'b1;
    end
    flags_next = flags_next & `FLAG_MASK;
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      flags_reg <= `RST16;
      trg_prev_reg <= 1'b0;
    end else begin
      flags_reg <= flags_next;
      trg_prev_reg <= trigger_input_i;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Enable and event generation registers.

  // Generation bits live for exactly one cycle after the write, then clear.
  always @(posedge clk_i) begin
    if (rst_i) begin
      enable_reg <= `RST16;
      gen_reg <= `RST16;
    end else begin
      if (wr_enable) begin
        enable_reg <= ((wdat & lane) | (enable_reg & ~lane)) & `ENABLE_MASK;
      end
      gen_reg <= wr_gen ? (wdat & lane & `GEN_MASK) : `RST16;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Channel control register.

  // Each channel byte is guarded on its own, so a locked channel 0 does not
  // stop a half-word write from reaching channel 1.
  always @* begin
    chctl_next = chctl_reg;
    if (wr_chctl) begin
      for (k = 0; k < 2; k = k + 1) begin
        if (sel_i[k]) begin
          chctl_next[`CH_SPAN*k+`CF_CEN] = wdat[`CH_SPAN*k+`CF_CEN];
          chctl_next[`CH_SPAN*k+`CF_FEN] = wdat[`CH_SPAN*k+`CF_FEN];
          if (!(write_protect_level_i == `WRITE_PROTECT_LEVEL_FULL &&
                chctl_reg[`CH_SPAN*k+`CF_MS +: 2] == `MODE_OUT)) begin
            chctl_next[`CH_SPAN*k+`CF_CTL +: 3] = wdat[`CH_SPAN*k+`CF_CTL +: 3];
            chctl_next[`CH_SPAN*k+`CF_SEN] = wdat[`CH_SPAN*k+`CF_SEN];
          end
          if (!ch_enable_i[k]) begin
            chctl_next[`CH_SPAN*k+`CF_MS +: 2] = wdat[`CH_SPAN*k+`CF_MS +: 2];
          end
        end
      end
    end
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      chctl_reg <= `RST16;
    end else begin
      chctl_reg <= chctl_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Compare values.

  // The preload copy is what software reads back; the active copy feeds the
  // comparator. A capture writes both so the captured count reads at once.
  always @(posedge clk_i) begin
    if (rst_i) begin
      for (m = 0; m < 2; m = m + 1) begin
        cv_pre_reg[m] <= {CNT_W{1'b0}};
        cv_act_reg[m] <= {CNT_W{1'b0}};
      end
    end else begin
      for (m = 0; m < 2; m = m + 1) begin
        if (cap_evt[m]) begin
          cv_pre_reg[m] <= timer_count_value_i;
          cv_act_reg[m] <= timer_count_value_i;
        end else if ((m == 0 && wr_cv0) || (m == 1 && wr_cv1)) begin
          cv_pre_reg[m] <= dat_i[CNT_W-1:0];
          if (!chctl_reg[`CH_SPAN*m+`CF_SEN]) begin
            cv_act_reg[m] <= dat_i[CNT_W-1:0];
          end
        end else if (upd_evt && chctl_reg[`CH_SPAN*m+`CF_SEN]) begin
          cv_act_reg[m] <= cv_pre_reg[m];
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Reference units.

  cmp_ref_unit #(
    .CNT_W(CNT_W)
  ) u_ref0 (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .mode_i(chctl_reg[`CF_CTL +: 3]),
    .clear_en_i(chctl_reg[`CF_CEN]),
    .ext_clear_i(filtered_ext_trigger_i),
    .out_mode_i(!ch_in[0]),
    .count_i(timer_count_value_i),
    .cmp_i(cv_act_reg[0]),
    .count_down_i(count_down_i),
    .ref_o(ref_w[0]),
    .match_evt_o(match_w[0])
  );

  cmp_ref_unit #(
    .CNT_W(CNT_W)
  ) u_ref1 (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .mode_i(chctl_reg[`CH_SPAN+`CF_CTL +: 3]),
    .clear_en_i(chctl_reg[`CH_SPAN+`CF_CEN]),
    .ext_clear_i(filtered_ext_trigger_i),
    .out_mode_i(!ch_in[1]),
    .count_i(timer_count_value_i),
    .cmp_i(cv_act_reg[1]),
    .count_down_i(count_down_i),
    .ref_o(ref_w[1]),
    .match_evt_o(match_w[1])
  );

  ////////////////////////////////////////////////////////////////////////////
  // Requests and outputs.

  // Interrupt level follows flags one cycle later; DMA requests are pulses.
  always @(posedge clk_i) begin
    if (rst_i) begin
      irq_o <= 1'b0;
      update_dma_req_o <= 1'b0;
      ch_zero_dma_req_o <= 1'b0;
      counter_reinit_o <= 1'b0;
      ch_ref_o <= 2'b00;
      ch_zero_out_o <= 1'b0;
      ch_zero_out_compl_o <= 1'b0;
      ch_one_out_o <= 1'b0;
    end else begin
      irq_o <= |(flags_reg[`BIT_TRG:`BIT_UPD] & enable_reg[`BIT_TRG:`BIT_UPD]);
      update_dma_req_o <= upd_evt & enable_reg[`BIT_UPD_DMA];
      ch_zero_dma_req_o <= ch_evt[0] & enable_reg[`BIT_CH0_DMA];
      counter_reinit_o <= gen_reg[`BIT_UPD];
      ch_ref_o <= ref_w;
      ch_zero_out_o <= ref_w[0] ^ ch_zero_out_polarity_i;
      ch_zero_out_compl_o <= !ref_w[0] ^ ch_zero_compl_polarity_i;
      ch_one_out_o <= ref_w[1] ^ ch_one_out_polarity_i;
    end
  end

endmodule // timer_event_flags_and_compare_ctl
`default_nettype wire

// ===== testbench/timer_evt_checker_properties.sv
`timescale 1ns/1ps
`default_nettype none
`include "timer_evt_defs.vh"
module timer_evt_checker (
  // Clock, reset and bus.
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [7:0] adr_i,
  input wire logic [31:0] dat_i,
  input wire logic [3:0] sel_i,
  input wire logic we_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic ack_o,
  // Timer side.
  input wire logic hw_update_i,
  input wire logic trigger_input_i,
  input wire logic [2:0] slave_mode_i,
  input wire logic [3:0] ch_enable_i,
  input wire logic [1:0] write_protect_level_i,
  input wire logic filtered_ext_trigger_i,
  input wire logic irq_o,
  input wire logic update_dma_req_o,
  input wire logic ch_zero_dma_req_o,
  input wire logic counter_reinit_o,
  input wire logic [1:0] ch_ref_o
);
  logic [15:0] en_reg;
  logic [7:0] cz_reg;
  logic wr_ack, sw_upd, ref_low, ref_high;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  //////////////////////////////////////////////////////////////////////
  // A write lands on the edge where ack is high.
  assign wr_ack = ack_o && cyc_i && stb_i && we_i;
  assign sw_upd = wr_ack && adr_i == `OFS_EVGEN && sel_i[0] && dat_i[`BIT_UPD];
  // Forced levels count only in output mode; the clear input beats force high.
  assign ref_low = cz_reg[1:0] == 2'b00 && (cz_reg[6:4] == 3'b100 || (cz_reg[7] && filtered_ext_trigger_i));
  assign ref_high = cz_reg[1:0] == 2'b00 && cz_reg[6:4] == 3'b101 && !(cz_reg[7] && filtered_ext_trigger_i);
  // Mirror of the enables and channel 0 byte, so locked writes are not mirrored.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      en_reg <= 16'h0000;
      cz_reg <= 8'h00;
    end else if (wr_ack && sel_i[0]) begin
      if (adr_i == `OFS_ENABLE) en_reg <= dat_i[15:0] & `ENABLE_MASK;
      if (adr_i == `OFS_CHCTL && !ch_enable_i[0]) cz_reg[1:0] <= dat_i[1:0];
      if (adr_i == `OFS_CHCTL && !(write_protect_level_i == 2'b11 && cz_reg[1:0] == 2'b00)) cz_reg[6:3] <= dat_i[6:3];
      if (adr_i == `OFS_CHCTL) cz_reg[7] <= dat_i[7];
    end
  end
  //////////////////////////////////////////////////////////////////////
  a_ack_pulse: assert property (ack_o |=> !ack_o)
    else $error("ack held past one cycle");
  a_ack_answer: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
    else $error("no ack one cycle after request");
  a_upd_dma_gate: assert property (update_dma_req_o |-> $past(en_reg[8]))
    else $error("update request while disabled");
  a_upd_dma_hw: assert property (hw_update_i && en_reg[8] |=> update_dma_req_o)
    else $error("update request missing");
  a_ch0_dma_gate: assert property (ch_zero_dma_req_o |-> $past(en_reg[9]))
    else $error("channel request while disabled");
  a_irq_gate: assert property (!$past(|(en_reg[6:0] & 7'h5f)) |-> !irq_o)
    else $error("irq with all enables off");
  a_pause_trig: assert property (en_reg[6] && slave_mode_i == 3'b101 &&
      $changed(trigger_input_i) |-> ##[2:3] irq_o)
    else $error("pause edge raised no irq");
  a_sw_reinit: assert property (sw_upd |-> ##[1:3] counter_reinit_o)
    else $error("no counter reinit after update gen");
  a_sw_upd_dma: assert property (sw_upd && en_reg[8] |-> ##[1:4] update_dma_req_o)
    else $error("no request after update gen");
  a_ref_low: assert property (ref_low [*4] |-> !ch_ref_o[0])
    else $error("reference not low");
  a_ref_high: assert property (ref_high [*4] |-> ch_ref_o[0])
    else $error("reference not high");
endmodule // timer_evt_checker
bind timer_event_flags_and_compare_ctl timer_evt_checker chk_u (
  .clk_i, .rst_i, .adr_i, .dat_i, .sel_i, .we_i, .cyc_i, .stb_i, .ack_o, .hw_update_i, .trigger_input_i,
  .slave_mode_i, .ch_enable_i, .write_protect_level_i, .filtered_ext_trigger_i, .irq_o, .update_dma_req_o,
  .ch_zero_dma_req_o, .counter_reinit_o, .ch_ref_o
);
`default_nettype wire

// ===== testbench/timer_event_flags_and_compare_ctl_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "timer_evt_defs.vh"
`define CHECK(nm, e, g) begin \
  compares++; \
  if ((g) !== (e)) begin \
    fails++; \
    $display("MISMATCH %s expected %h seen %h", nm, e, g); \
  end \
end
module timer_event_flags_and_compare_ctl_tb;
  // Stimulus, all idle at time zero.
  logic clk_i = 1'b0, rst_i = 1'b1, we_i = 1'b0, cyc_i = 1'b0, stb_i = 1'b0;
  logic [7:0] adr_i = 8'h00;
  logic [31:0] dat_i = 32'h0;
  logic [3:0] sel_i = 4'h0, ch_enable_i = 4'h0, ch_hw_evt_i = 4'h0;
  logic [15:0] timer_count_value_i = 16'h0100;
  logic count_down_i = 1'b0, hw_update_i = 1'b0, trigger_input_i = 1'b0, filtered_ext_trigger_i = 1'b0;
  logic [2:0] slave_mode_i = 3'h0;
  logic [1:0] ch_upper_input_i = 2'h0, write_protect_level_i = 2'h0;
  logic ch_zero_out_polarity_i = 1'b1, ch_zero_compl_polarity_i = 1'b1, ch_one_out_polarity_i = 1'b1;
  // Observed outputs.
  logic [31:0] dat_o;
  logic [1:0] ch_ref_o;
  logic ack_o, irq_o, update_dma_req_o, ch_zero_dma_req_o, counter_reinit_o;
  logic ch_zero_out_o, ch_zero_out_compl_o, ch_one_out_o;
  int fails = 0, compares = 0, cycles = 0, n_upd = 0, n_cdma = 0, n_reinit = 0;

  timer_event_flags_and_compare_ctl dut_u (.clk_i, .rst_i, .adr_i, .dat_i, .sel_i, .we_i, .cyc_i, .stb_i,
    .dat_o, .ack_o, .timer_count_value_i, .count_down_i, .hw_update_i, .trigger_input_i, .slave_mode_i,
    .ch_enable_i, .ch_hw_evt_i, .ch_upper_input_i, .write_protect_level_i, .filtered_ext_trigger_i,
    .ch_zero_out_polarity_i, .ch_zero_compl_polarity_i, .ch_one_out_polarity_i, .irq_o, .update_dma_req_o,
    .ch_zero_dma_req_o, .counter_reinit_o, .ch_ref_o, .ch_zero_out_o, .ch_zero_out_compl_o, .ch_one_out_o);

  //////////////////////////////////////////////////////////////////////
  always #5 clk_i = ~clk_i;
  // Pulses are counted here so a scenario can judge them afterwards; a hang ends the run.
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    n_upd += (update_dma_req_o === 1'b1);
    n_cdma += (ch_zero_dma_req_o === 1'b1);
    n_reinit += (counter_reinit_o === 1'b1);
    if (cycles == 20000) begin
      fails++;
      end_of_test();
    end
  end

  //////////////////////////////////////////////////////////////////////
  // One classic cycle; the master never assumes how soon ack comes.
  task automatic wb(input logic [7:0] a, input logic w, input logic [15:0] d, output logic [15:0] q);
    @(posedge clk_i);
    adr_i <= a;
    we_i <= w;
    dat_i <= {16'h0000, d};
    sel_i <= 4'h3;
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    do @(posedge clk_i); while (ack_o !== 1'b1);
    q = dat_o[15:0];
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    we_i <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    logic [15:0] q;
    wb(a, 1'b1, d, q);
  endtask
  task automatic rd(input logic [7:0] a, input logic [15:0] e, input string nm);
    logic [15:0] q;
    wb(a, 1'b0, 16'h0000, q);
    `CHECK(nm, e, q)
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  // Input changes hold for a few cycles so edge detectors see them.
  task automatic cnt(input logic [15:0] v);
    @(posedge clk_i);
    timer_count_value_i <= v;
    tick(3);
  endtask
  task automatic trig(input logic v);
    @(posedge clk_i);
    trigger_input_i <= v;
    tick(3);
  endtask
  task automatic upd_pulse();
    @(posedge clk_i);
    hw_update_i <= 1'b1;
    @(posedge clk_i);
    hw_update_i <= 1'b0;
    tick(3);
  endtask
  // All polarity inputs are 1, so the main output inverts and the complement follows.
  task automatic ref_is(input logic e, input string nm);
    tick(4);
    `CHECK(nm, e, ch_ref_o[0])
    `CHECK(nm, ~e, ch_zero_out_o)
    `CHECK(nm, e, ch_zero_out_compl_o)
    `CHECK(nm, 1'b1, ch_one_out_o)
  endtask

  //////////////////////////////////////////////////////////////////////
  task automatic t_regs();
    rd(`OFS_ENABLE, 16'h0000, "enable reset");
    rd(`OFS_FLAGS, 16'h0000, "flags reset");
    rd(`OFS_CHCTL, 16'h0000, "chctl reset");
    wr(8'h40, 16'hffff);
    rd(8'h40, 16'h0000, "unmapped");
    wr(`OFS_ENABLE, 16'hffff);
    rd(`OFS_ENABLE, `ENABLE_MASK, "enable bits");
    wr(`OFS_ENABLE, 16'h0001);
    $display("regs done");
  endtask
  task automatic t_update();
    upd_pulse();
    `CHECK("dma gated", 0, n_upd)
    `CHECK("irq", 1'b1, irq_o)
    rd(`OFS_FLAGS, 16'h0001, "upd flag");
    wr(`OFS_FLAGS, 16'hffff);
    rd(`OFS_FLAGS, 16'h0001, "flag kept");
    wr(`OFS_FLAGS, 16'h0000);
    rd(`OFS_FLAGS, 16'h0000, "flag cleared");
    `CHECK("irq off", 1'b0, irq_o)
    wr(`OFS_ENABLE, 16'h0100);
    upd_pulse();
    `CHECK("upd dma", 1, n_upd)
    `CHECK("irq masked", 1'b0, irq_o)
    wr(`OFS_FLAGS, 16'h0000);
    $display("update done");
  endtask
  task automatic t_swgen();
    wr(`OFS_ENABLE, 16'h0343);
    timer_count_value_i <= 16'h0123;
    wr(`OFS_EVGEN, 16'h0043);
    tick(4);
    `CHECK("reinit", 1, n_reinit)
    `CHECK("sw upd dma", 2, n_upd)
    `CHECK("ch0 dma", 1, n_cdma)
    rd(`OFS_FLAGS, 16'h0043, "sw flags");
    rd(`OFS_EVGEN, 16'h0000, "gen reads 0");
    wr(`OFS_CHCTL, 16'h0001);
    wr(`OFS_EVGEN, 16'h0002);
    tick(3);
    rd(`OFS_FLAGS, 16'h0243, "overcapture");
    rd(`OFS_CV0, 16'h0123, "capture");
    cnt(16'h0100);
    wr(`OFS_CHCTL, 16'h0000);
    wr(`OFS_FLAGS, 16'h0000);
    $display("swgen done");
  endtask
  task automatic t_trigger();
    wr(`OFS_ENABLE, 16'h0040);
    trig(1'b1);
    trig(1'b0);
    rd(`OFS_FLAGS, 16'h0000, "trg off");
    slave_mode_i <= 3'b100;
    trig(1'b1);
    rd(`OFS_FLAGS, 16'h0040, "trg rise");
    `CHECK("trg irq", 1'b1, irq_o)
    wr(`OFS_FLAGS, 16'h0000);
    trig(1'b0);
    rd(`OFS_FLAGS, 16'h0000, "trg fall");
    slave_mode_i <= 3'b101;
    trig(1'b1);
    wr(`OFS_FLAGS, 16'h0000);
    trig(1'b0);
    rd(`OFS_FLAGS, 16'h0040, "pause fall");
    slave_mode_i <= 3'b000;
    wr(`OFS_FLAGS, 16'h0000);
    $display("trigger done");
  endtask
  // Two hardware captures on channel 2: the second finds its flag set.
  task automatic t_hwcap();
    ch_upper_input_i <= 2'b01;
    repeat (2) begin
      @(posedge clk_i);
      ch_hw_evt_i <= 4'h4;
      @(posedge clk_i);
      ch_hw_evt_i <= 4'h0;
    end
    tick(2);
    rd(`OFS_FLAGS, 16'h0808, "hw capture");
    wr(`OFS_FLAGS, 16'h0000);
    ch_upper_input_i <= 2'b00;
    $display("hwcap done");
  endtask
  task automatic t_mode();
    ch_enable_i <= 4'h3;
    wr(`OFS_CHCTL, 16'h0302);
    rd(`OFS_CHCTL, 16'h0000, "mode locked");
    ch_enable_i <= 4'h0;
    for (int m = 3; m >= 0; m--) begin
      wr(`OFS_CHCTL, {6'h00, m[1:0], 6'h00, m[1:0]});
      rd(`OFS_CHCTL, {6'h00, m[1:0], 6'h00, m[1:0]}, "mode field");
    end
    // Channel 1 reference follows its own control byte.
    wr(`OFS_CHCTL, 16'h5000);
    tick(4);
    `CHECK("ch1 force high", 2'b10, ch_ref_o)
    `CHECK("ch1 out", 1'b0, ch_one_out_o)
    wr(`OFS_CHCTL, 16'h4000);
    wr(`OFS_CHCTL, 16'h0000);
    $display("mode done");
  endtask
  task automatic t_ref();
    wr(`OFS_CV0, 16'h0010);
    wr(`OFS_CHCTL, 16'h0050);
    ref_is(1'b1, "force high");
    wr(`OFS_CHCTL, 16'h0040);
    ref_is(1'b0, "force low");
    wr(`OFS_CHCTL, 16'h0010);
    cnt(16'h0010);
    ref_is(1'b1, "set on match");
    rd(`OFS_FLAGS, 16'h0002, "cmp flag");
    wr(`OFS_CHCTL, 16'h0020);
    cnt(16'h0100);
    cnt(16'h0010);
    ref_is(1'b0, "clear on match");
    wr(`OFS_CHCTL, 16'h0030);
    cnt(16'h0100);
    cnt(16'h0010);
    ref_is(1'b1, "toggle");
    wr(`OFS_CHCTL, 16'h0000);
    cnt(16'h0100);
    cnt(16'h0010);
    ref_is(1'b1, "frozen");
    cnt(16'h0005);
    wr(`OFS_CHCTL, 16'h0060);
    ref_is(1'b1, "pwm0 below");
    cnt(16'h0020);
    ref_is(1'b0, "pwm0 above");
    count_down_i <= 1'b1;
    cnt(16'h0008);
    ref_is(1'b1, "pwm0 down");
    wr(`OFS_CHCTL, 16'h0000);
    wr(`OFS_CHCTL, 16'h0070);
    ref_is(1'b0, "pwm1 entry");
    cnt(16'h0020);
    ref_is(1'b1, "pwm1 down");
    count_down_i <= 1'b0;
    wr(`OFS_CHCTL, 16'h00d0);
    filtered_ext_trigger_i <= 1'b1;
    ref_is(1'b0, "ext clear");
    filtered_ext_trigger_i <= 1'b0;
    ref_is(1'b1, "clear gone");
    write_protect_level_i <= 2'b11;
    wr(`OFS_CHCTL, 16'h0048);
    rd(`OFS_CHCTL, 16'h0050, "locked ctl");
    ref_is(1'b1, "locked ref");
    write_protect_level_i <= 2'b00;
    wr(`OFS_CHCTL, 16'h0000);
    wr(`OFS_CHCTL, 16'h0068);
    wr(`OFS_CV0, 16'h0030);
    ref_is(1'b0, "shadow held");
    upd_pulse();
    ref_is(1'b1, "shadow loaded");
    $display("ref done");
  endtask

  //////////////////////////////////////////////////////////////////////
  task automatic end_of_test();
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // Main sequence after the reset hold.
  initial begin
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    t_regs();
    t_update();
    t_swgen();
    t_trigger();
    t_hwcap();
    t_mode();
    t_ref();
    end_of_test();
  end
endmodule // timer_event_flags_and_compare_ctl_tb
`default_nettype wire
